// [src/md_pkg.sv]
// shared constants and types of the integer multiply and divide datapath
package md_pkg;

   // ***********************************
   // widths
   // ***********************************
   localparam int XLEN = 32;
   localparam int DLEN = 64;
   localparam int SIMM_W = 13;
   localparam int ADDR_W = 8;

   // ***********************************
   // instruction fields
   // ***********************************
   localparam int OPC_HI = 24;
   localparam int OPC_LO = 19;
   localparam int IMM_SEL_BIT = 13;
   localparam int SRC2_HI = 4;
   localparam int SRC2_LO = 0;
   localparam int SIMM_HI = 12;
   localparam int OPC_SIGNED_BIT = 0;
   localparam int OPC_CC_BIT = 4;

   // ***********************************
   // operation codes
   // ***********************************
   localparam logic [5:0] OP_UMUL = 6'h0A;
   localparam logic [5:0] OP_SMUL = 6'h0B;
   localparam logic [5:0] OP_UMULCC = 6'h1A;
   localparam logic [5:0] OP_SMULCC = 6'h1B;
   localparam logic [5:0] OP_UDIV = 6'h0E;
   localparam logic [5:0] OP_SDIV = 6'h0F;
   localparam logic [5:0] OP_UDIVCC = 6'h1E;
   localparam logic [5:0] OP_SDIVCC = 6'h1F;

   // ***********************************
   // divide saturation values
   // ***********************************
   localparam logic [31:0] SAT_U = 32'hFFFF_FFFF;
   localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
   localparam logic [31:0] SAT_NEG = 32'h8000_0000;
   localparam logic DIV_NEG_METHOD_B = 1'h0;

   // ***********************************
   // register map
   // ***********************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_OP_COUNT = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_REM_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0003;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   localparam int EV_DONE_BIT = 0;
   localparam int EV_TRAP_BIT = 1;
   localparam int EV_OVF_BIT = 2;
   localparam logic [31:0] EV_MASK = 32'h0000_0007;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic RESP_OKAY = 1'h0;

   // ***********************************
   // types
   // ***********************************
   typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_DIV} state_t;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } icc_t;

   typedef struct packed {
      logic [31:0] instruction;
      logic [31:0] src1;
      logic [31:0] src2;
      logic [31:0] y;
   } issue_t;

   typedef struct packed {
      logic valid;
      logic trap;
      logic rd_write;
      logic [31:0] rd_data;
      logic y_write;
      logic [31:0] y_data;
      logic icc_write;
      icc_t icc;
   } result_t;

endpackage

// [src/md_multiplier.sv]
// one-cycle registered 32 by 32 multiplier, signed or unsigned
`timescale 1ns/1ps
module md_multiplier #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request
   input wire logic start,
   input wire logic is_signed,
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   // answer
   output logic done,
   output logic [2*W-1:0] product
);
   logic signed [2*W+1:0] full;

   // operands extended to the product width, so one multiplier serves both signednesses
   assign full = $signed({{(W+2){is_signed & a[W-1]}}, a}) *
      $signed({{(W+2){is_signed & b[W-1]}}, b});

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done <= 1'b0;
         product <= '0;
      end else begin
         done <= start;
         if (start) begin
            product <= full[2*W-1:0];
         end
      end
   end
endmodule

// [src/md_divider.sv]
// restoring divider on magnitudes, one quotient bit per cycle
`timescale 1ns/1ps
module md_divider #(
   parameter int NW = 64,
   parameter int DW = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // request
   input wire logic start,
   input wire logic [NW-1:0] dividend,
   input wire logic [DW-1:0] divisor,
   // answer
   output logic busy,
   output logic done,
   output logic [NW-1:0] quotient,
   output logic [DW-1:0] remainder
);
   localparam int CW = $clog2(NW + 1);
   logic [CW-1:0] cnt;
   logic [DW-1:0] dvs;
   logic [DW:0] trial;

   assign busy = (cnt != '0);
   assign trial = {remainder, quotient[NW-1]};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
         done <= 1'b0;
         dvs <= '0;
         quotient <= '0;
         remainder <= '0;
      end else begin
         done <= (cnt == CW'(1));
         if (start) begin
            cnt <= CW'(NW);
            dvs <= divisor;
            quotient <= dividend;
            remainder <= '0;
         end else if (busy) begin
            cnt <= cnt - CW'(1);
            // remainder stays below the divisor, so the trial fits in DW+1 bits
            if (trial >= {1'b0, dvs}) begin
               remainder <= DW'(trial - {1'b0, dvs});
               quotient <= {quotient[NW-2:0], 1'b1};
            end else begin
               remainder <= trial[DW-1:0];
               quotient <= {quotient[NW-2:0], 1'b0};
            end
         end
      end
   end
endmodule

// [src/int_mul_div_datapath.sv]
// integer multiply and divide execution datapath with an ahb-lite register slave
//
// What this block does
// - flag multiplies set negative from product bit 31, zero from low word.
// - flag multiplies clear overflow and carry flags.
// - operation codes 001110/001111/011110/011111 are the four divide variants.
// - dividend is high word over first source; divisor register or immediate.
// - remainder never goes to destination; optionally placed in high word.
// - unsigned divides use unsigned values, signed divides two's complement.
// - signed quotients round toward zero; remainder takes dividend sign.
// - unsigned overflow saturates destination to all ones.
// - signed positive overflow saturates to largest positive word.
// - signed negative overflow saturates to most negative word.
// - one negative overflow method, selected once, used always.
// - saturated quotient written for every divide variant.
// - plain divides keep flags; flag divides set n and z after saturation.
// - flag divides set overflow from overflow test, carry always cleared.
// - multiply writes high product word to high word, low to destination.
`timescale 1ns/1ps
module int_mul_div_datapath #(
   parameter logic NEG_METHOD_B = md_pkg::DIV_NEG_METHOD_B
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // issue from decode
   input wire logic issue_valid,
   input wire md_pkg::issue_t issue,
   output logic issue_ready,
   output logic [4:0] src2_index,
   // writeback
   output md_pkg::result_t result,
   // interrupt
   output logic irq
);
   // ***********************************
   // decode
   // ***********************************
   logic [5:0] opc;
   logic [31:0] operand2;
   logic is_mul, is_div, div_zero, accept;
   md_pkg::state_t state;
   logic [31:0] ctrl, irq_stat, irq_mask, op_count;

   assign opc = issue.instruction[md_pkg::OPC_HI:md_pkg::OPC_LO];
   assign src2_index = issue.instruction[md_pkg::SRC2_HI:md_pkg::SRC2_LO];
   assign operand2 = issue.instruction[md_pkg::IMM_SEL_BIT] ?
      {{(md_pkg::XLEN - md_pkg::SIMM_W){issue.instruction[md_pkg::SIMM_HI]}},
       issue.instruction[md_pkg::SIMM_HI:0]} : issue.src2;

   always_comb begin
      is_mul = 1'b0;
      is_div = 1'b0;
      case (opc)
         md_pkg::OP_UMUL, md_pkg::OP_SMUL, md_pkg::OP_UMULCC, md_pkg::OP_SMULCC: is_mul = 1'b1;
         md_pkg::OP_UDIV, md_pkg::OP_SDIV, md_pkg::OP_UDIVCC, md_pkg::OP_SDIVCC: is_div = 1'b1;
         default: ;
      endcase
   end

   assign div_zero = is_div && (operand2 == '0);
   assign issue_ready = (state == md_pkg::ST_IDLE) && ctrl[md_pkg::CTRL_EN_BIT];
   assign accept = issue_valid && issue_ready;

   // ***********************************
   // sequencing
   // ***********************************
   logic mul_done, div_done;
   logic cur_signed, cur_cc, dvd_neg, dvs_neg;
   logic [5:0] cur_op;
   logic now_signed, now_dvd_neg, now_dvs_neg;
   logic [63:0] dvd, dvd_mag, product, q_mag;
   logic [31:0] dvs_mag, r_mag;

   assign now_signed = opc[md_pkg::OPC_SIGNED_BIT];
   assign now_dvd_neg = now_signed && issue.y[md_pkg::XLEN-1];
   assign now_dvs_neg = now_signed && operand2[md_pkg::XLEN-1];
   assign dvd = {issue.y, issue.src1};
   assign dvd_mag = now_dvd_neg ? -dvd : dvd;
   assign dvs_mag = now_dvs_neg ? -operand2 : operand2;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= md_pkg::ST_IDLE;
      end else begin
         case (state)
            md_pkg::ST_IDLE: begin
               if (accept && is_mul) begin
                  state <= md_pkg::ST_MUL;
               end else if (accept && is_div && !div_zero) begin
                  state <= md_pkg::ST_DIV;
               end
            end
            md_pkg::ST_MUL: if (mul_done) state <= md_pkg::ST_IDLE;
            md_pkg::ST_DIV: if (div_done) state <= md_pkg::ST_IDLE;
            default: state <= md_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_op <= '0;
         cur_signed <= 1'b0;
         cur_cc <= 1'b0;
         dvd_neg <= 1'b0;
         dvs_neg <= 1'b0;
      end else if (accept) begin
         cur_op <= opc;
         cur_signed <= now_signed;
         cur_cc <= opc[md_pkg::OPC_CC_BIT];
         dvd_neg <= now_dvd_neg;
         dvs_neg <= now_dvs_neg;
      end
   end

   md_multiplier #(.W(md_pkg::XLEN)) u_mul (
      .clk(hclk),
      .rstn(hresetn),
      .start(accept && is_mul),
      .is_signed(now_signed),
      .a(issue.src1),
      .b(operand2),
      .done(mul_done),
      .product(product)
   );

   md_divider #(.NW(md_pkg::DLEN), .DW(md_pkg::XLEN)) u_div (
      .clk(hclk),
      .rstn(hresetn),
      .start(accept && is_div && !div_zero),
      .dividend(dvd_mag),
      .divisor(dvs_mag),
      .busy(),
      .done(div_done),
      .quotient(q_mag),
      .remainder(r_mag)
   );

   // ***********************************
   // divide result shaping
   // ***********************************
   logic neg_q, div_ovf;
   logic [31:0] div_quot, div_rem;

   always_comb begin
      neg_q = cur_signed && (dvd_neg ^ dvs_neg);
      if (!cur_signed) begin
         div_ovf = q_mag > 64'(md_pkg::SAT_U);
      end else if (!neg_q) begin
         div_ovf = q_mag > 64'(md_pkg::SAT_POS);
      end else if (NEG_METHOD_B) begin
         // exact limit only, so a limit quotient with remainder overflows
         div_ovf = (q_mag > 64'(md_pkg::SAT_NEG)) ||
                   ((q_mag == 64'(md_pkg::SAT_NEG)) && (r_mag != '0));
      end else begin
         div_ovf = q_mag > 64'(md_pkg::SAT_NEG);
      end
      if (div_ovf) begin
         div_quot = !cur_signed ? md_pkg::SAT_U : (neg_q ? md_pkg::SAT_NEG : md_pkg::SAT_POS);
      end else begin
         div_quot = neg_q ? -q_mag[31:0] : q_mag[31:0];
      end
      div_rem = dvd_neg ? -r_mag : r_mag;
   end

   // ***********************************
   // writeback
   // ***********************************
   md_pkg::result_t next_res;
   logic next_ovf, last_ovf;
   logic [5:0] res_op;
   logic res_ovf;

   always_comb begin
      next_res = '0;
      next_ovf = 1'b0;
      if (accept && !is_mul && !(is_div && !div_zero)) begin
         // unknown codes answer too, with nothing written, so decode never hangs
         next_res.valid = 1'b1;
         next_res.trap = div_zero;
      end else if (state == md_pkg::ST_MUL && mul_done) begin
         next_res.valid = 1'b1;
         next_res.rd_write = 1'b1;
         next_res.rd_data = product[31:0];
         next_res.y_write = 1'b1;
         next_res.y_data = product[63:32];
         next_res.icc_write = cur_cc;
         next_res.icc.n = product[31];
         next_res.icc.z = (product[31:0] == '0);
         next_res.icc.v = 1'b0;
         next_res.icc.c = 1'b0;
      end else if (state == md_pkg::ST_DIV && div_done) begin
         next_ovf = div_ovf;
         next_res.valid = 1'b1;
         next_res.rd_write = 1'b1;
         next_res.rd_data = div_quot;
         next_res.y_write = ctrl[md_pkg::CTRL_REM_BIT];
         next_res.y_data = div_rem;
         next_res.icc_write = cur_cc;
         next_res.icc.n = div_quot[31];
         next_res.icc.z = (div_quot == '0);
         next_res.icc.v = div_ovf;
         next_res.icc.c = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result <= '0;
         res_op <= '0;
         res_ovf <= 1'b0;
      end else begin
         result <= next_res;
         res_op <= accept ? opc : cur_op;
         res_ovf <= next_ovf;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_ovf <= 1'b0;
         op_count <= '0;
      end else if (next_res.valid) begin
         last_ovf <= next_ovf;
         op_count <= op_count + 32'h0000_0001;
      end
   end

   // ***********************************
   // ahb-lite slave
   // ***********************************
   logic addr_ok, wr_pend, rd_wait;
   logic [md_pkg::ADDR_W-1:0] bus_addr;
   logic [31:0] rd_mux, ev_set, ev_clr;

   assign addr_ok = hsel && htrans[1] && hready;
   // one wait state on reads lets a write just before land first
   assign hreadyout = !rd_wait;
   assign hresp = md_pkg::RESP_OKAY;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_wait <= 1'b0;
         bus_addr <= '0;
      end else begin
         wr_pend <= addr_ok && hwrite && (hsize == md_pkg::HSIZE_WORD);
         rd_wait <= addr_ok && !hwrite;
         if (addr_ok) begin
            bus_addr <= haddr[md_pkg::ADDR_W-1:0];
         end
      end
   end

   always_comb begin
      case (bus_addr)
         md_pkg::REG_CTRL: rd_mux = ctrl;
         md_pkg::REG_STATUS: begin
            rd_mux = '0;
            rd_mux[md_pkg::STAT_BUSY_BIT] = (state != md_pkg::ST_IDLE);
            rd_mux[md_pkg::STAT_OVF_BIT] = last_ovf;
         end
         md_pkg::REG_IRQ_STAT: rd_mux = irq_stat;
         md_pkg::REG_IRQ_MASK: rd_mux = irq_mask;
         md_pkg::REG_OP_COUNT: rd_mux = op_count;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (rd_wait) begin
         hrdata <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= md_pkg::CTRL_RESET;
      end else if (wr_pend && bus_addr == md_pkg::REG_CTRL) begin
         ctrl <= hwdata & md_pkg::CTRL_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= '0;
      end else if (wr_pend && bus_addr == md_pkg::REG_IRQ_MASK) begin
         irq_mask <= hwdata & md_pkg::EV_MASK;
      end
   end

   // ***********************************
   // interrupts
   // ***********************************
   always_comb begin
      ev_set = '0;
      ev_set[md_pkg::EV_DONE_BIT] = next_res.valid;
      ev_set[md_pkg::EV_TRAP_BIT] = next_res.trap;
      ev_set[md_pkg::EV_OVF_BIT] = next_ovf;
      ev_clr = (wr_pend && bus_addr == md_pkg::REG_IRQ_STAT) ? hwdata : '0;
   end

   // a new event in the clearing cycle survives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= ((irq_stat & ~ev_clr) | ev_set) & md_pkg::EV_MASK;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic res_div, res_mul;
   // unknown codes with bit 2 set answer with nothing written and must not count as divides
   assign res_div = result.valid && !result.trap && res_op[2] && result.rd_write;
   assign res_mul = result.valid && !result.trap && !res_op[2] && result.rd_write;

   sequence div_issue_s;
      accept && is_div && !div_zero;
   endsequence
   sequence zero_issue_s;
      accept && div_zero;
   endsequence

   mul_flags_a: assert property (res_mul && result.icc_write |->
      result.icc.n == result.rd_data[31] && result.icc.z == (result.rd_data == '0))
      else $error("multiply n or z flag wrong");
   mul_vc_a: assert property (res_mul |-> !result.icc.v && !result.icc.c)
      else $error("multiply v or c not cleared");
   mul_latency_a: assert property (accept && is_mul |-> ##2 (result.valid && result.y_write))
      else $error("multiply result not in two cycles");
   div_latency_a: assert property (div_issue_s |-> ##66 (result.valid && result.rd_write))
      else $error("divide result not in sixty-six cycles");
   zero_trap_a: assert property (zero_issue_s |=>
      result.valid && result.trap && !result.rd_write && !result.icc_write)
      else $error("zero divisor not trapped cleanly");
   sat_unsigned_a: assert property (res_div && !res_op[0] && res_ovf |->
      result.rd_data == md_pkg::SAT_U)
      else $error("unsigned overflow not saturated");
   sat_signed_a: assert property (res_div && res_op[0] && res_ovf |->
      result.rd_data == md_pkg::SAT_POS || result.rd_data == md_pkg::SAT_NEG)
      else $error("signed overflow not saturated");
   div_flags_a: assert property (res_div |-> result.icc_write == res_op[4] &&
      result.icc.n == result.rd_data[31] && result.icc.z == (result.rd_data == '0))
      else $error("divide n or z flag wrong");
   div_vc_a: assert property (res_div |-> result.icc.v == res_ovf && !result.icc.c)
      else $error("divide v or c wrong");
   irq_stick_a: assert property (result.valid && !(wr_pend && bus_addr == md_pkg::REG_IRQ_STAT)
      |=> irq_stat[md_pkg::EV_DONE_BIT])
      else $error("done status lost");
endmodule

// [sim/issue_source.sv]
// decode-side model: offers one instruction at a time and collects its result
`timescale 1ns/1ps
module issue_source (
   // clock
   input wire logic hclk,
   // issue handshake
   input wire logic issue_ready,
   input wire logic [4:0] src2_index,
   output logic issue_valid,
   output md_pkg::issue_t issue,
   // writeback
   input wire md_pkg::result_t result
);
   logic [4:0] idx_seen;

   initial begin
      issue_valid = 1'h0;
      issue = '0;
      idx_seen = 5'h00;
   end

   // ***********************************
   // one request, held until accepted
   // ***********************************
   task automatic send(input md_pkg::issue_t req, output md_pkg::result_t res,
                       output logic ok);
      int n;
      n = 0;
      @(posedge hclk);
      issue_valid <= 1'h1;
      issue <= req;
      do begin
         @(posedge hclk);
         n++;
      end while (issue_ready !== 1'h1 && n < 20);
      idx_seen = src2_index;
      // released operands carry junk so a late sample cannot pass by luck
      issue_valid <= 1'h0;
      issue <= ~req;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (result.valid !== 1'h1 && n < 100);
      res = result;
      ok = (result.valid === 1'h1);
   endtask
endmodule

// [sim/tb.sv]
// self-checking bench of the multiply and divide datapath
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
   $display("mismatch %s expected %h seen %h", nm, ex, gt); fail_count++; end end
module tb;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq, issue_valid, issue_ready;
   logic [31:0] hrdata, q;
   logic [4:0] src2_index;
   md_pkg::issue_t issue;
   md_pkg::result_t result;
   int fail_count = 0;
   int cmp_count = 0;

   always #2.5 hclk = ~hclk;

   int_mul_div_datapath DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .issue_valid(issue_valid),
      .issue(issue), .issue_ready(issue_ready), .src2_index(src2_index), .result(result),
      .irq(irq));
   issue_source u_dec (.hclk(hclk), .issue_ready(issue_ready), .src2_index(src2_index),
      .issue_valid(issue_valid), .issue(issue), .result(result));

   // ***********************************
   // closing and bus helpers
   // ***********************************
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'h1 && n < 20);
      if (hreadyout !== 1'h1) begin
         $display("mismatch bus wait expected ready seen timeout");
         fail_count++;
         test_done;
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      hsize <= md_pkg::HSIZE_WORD;
      wait_rdy;
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
      `CHK("hresp", md_pkg::RESP_OKAY, hresp)
   endtask

   // ***********************************
   // one instruction through the decode model
   // ***********************************
   task automatic run(input logic [5:0] op, input logic i, input logic [12:0] low,
      input logic [31:0] s1, s2, y, rd, yd, input logic [3:0] nzvc, input logic tr,
      input logic ychk);
      md_pkg::issue_t req;
      md_pkg::result_t r;
      logic ok;
      req.instruction = {2'h2, 5'h01, op, 5'h02, i, low};
      req.src1 = s1;
      req.src2 = s2;
      req.y = y;
      u_dec.send(req, r, ok);
      if (!ok) begin
         $display("mismatch result wait expected valid seen timeout");
         fail_count++;
         test_done;
      end
      `CHK("src2 index", low[4:0], u_dec.idx_seen)
      `CHK("trap", tr, r.trap)
      `CHK("rd write", ~tr, r.rd_write)
      `CHK("icc write", op[4] & ~tr, r.icc_write)
      if (!tr) begin
         `CHK("rd data", rd, r.rd_data)
      end
      if (r.icc_write === 1'h1) begin
         `CHK("icc", nzvc, r.icc)
      end
      if (ychk) begin
         `CHK("y write", 1'h1, r.y_write)
         `CHK("y data", yd, r.y_data)
      end
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_regs;
      bus(1'h0, md_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl reset", md_pkg::CTRL_RESET, q)
      bus(1'h0, md_pkg::REG_IRQ_MASK, 32'h0);
      `CHK("mask reset", 32'h0, q)
      bus(1'h1, 8'h20, 32'hFFFF_FFFF);
      bus(1'h0, 8'h20, 32'h0);
      `CHK("unmapped", 32'h0, q)
      bus(1'h1, md_pkg::REG_CTRL, 32'h0);
      @(posedge hclk);
      #1;
      `CHK("ready when off", 1'h0, issue_ready)
      bus(1'h1, md_pkg::REG_CTRL, 32'h3);
      $display("test regs done");
   endtask

   task automatic t_mul;
      run(md_pkg::OP_UMULCC, 0, 13'h7, 32'hFFFF_FFFF, 2, 0, 32'hFFFF_FFFE, 1, 4'h8, 0, 1);
      run(md_pkg::OP_UMULCC, 0, 13'h7, 32'h1_0000, 32'h1_0000, 0, 0, 1, 4'h4, 0, 1);
      run(md_pkg::OP_SMUL, 1, 13'h1FFF, 5, 0, 0, 32'hFFFF_FFFB, 32'hFFFF_FFFF, 0, 0, 1);
      run(md_pkg::OP_UMUL, 0, 13'h7, '1, '1, 0, 1, 32'hFFFF_FFFE, 0, 0, 1);
      $display("test mul done");
   endtask

   task automatic t_div;
      run(md_pkg::OP_UDIVCC, 0, 13'h7, 100, 7, 0, 14, 2, 4'h0, 0, 1);
      run(md_pkg::OP_UDIVCC, 0, 13'h7, 3, 7, 0, 0, 3, 4'h4, 0, 1);
      run(md_pkg::OP_UDIVCC, 0, 13'h7, 0, 1, 1, '1, 0, 4'hA, 0, 0);
      bus(1'h0, md_pkg::REG_STATUS, 32'h0);
      `CHK("status ovf", 32'h1 << md_pkg::STAT_OVF_BIT, q)
      run(md_pkg::OP_SDIVCC, 0, 13'h7, -3, 2, '1, '1, '1, 4'h8, 0, 1);
      run(md_pkg::OP_SDIV, 0, 13'h7, 32'h8000_0000, 1, 0, 32'h7FFF_FFFF, 0, 0, 0, 0);
      run(md_pkg::OP_SDIVCC, 0, 13'h7, 32'h7FFF_FFFE, 1, '1, 32'h8000_0000, 0, 4'hA, 0,
         0);
      run(md_pkg::OP_SDIVCC, 0, 13'h7, '1, 2, -2, 32'h8000_0000, '1, 4'h8, 0, 1);
      run(md_pkg::OP_UDIV, 1, 13'h1FFE, 100, 0, 0, 0, 100, 0, 0, 1);
      run(md_pkg::OP_SDIVCC, 1, 13'h1FFE, 100, 0, 0, 32'hFFFF_FFCE, 0, 4'h8, 0, 1);
      run(md_pkg::OP_UDIVCC, 0, 13'h7, 100, 0, 0, 0, 0, 0, 1, 0);
      $display("test div done");
   endtask

   task automatic t_irq;
      bus(1'h1, md_pkg::REG_IRQ_STAT, md_pkg::EV_MASK);
      run(md_pkg::OP_UMUL, 0, 13'h7, 3, 4, 0, 12, 0, 0, 0, 1);
      bus(1'h0, md_pkg::REG_IRQ_STAT, 32'h0);
      `CHK("irq status", 32'h1, q)
      // four multiplies, ten divides and one multiply here, each answered once
      bus(1'h0, md_pkg::REG_OP_COUNT, 32'h0);
      `CHK("op count", 32'h0000_000F, q)
      `CHK("irq masked", 1'h0, irq)
      bus(1'h1, md_pkg::REG_IRQ_MASK, 32'h1);
      @(posedge hclk);
      #1;
      `CHK("irq raised", 1'h1, irq)
      bus(1'h1, md_pkg::REG_IRQ_STAT, 32'h1);
      @(posedge hclk);
      #1;
      `CHK("irq cleared", 1'h0, irq)
      $display("test irq done");
   endtask

   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs;
      t_mul;
      t_div;
      t_irq;
      test_done;
   end
endmodule
